// [design/irtp_target.sv]
// target end: register target port answering at a fixed bus address
// assumes scl/sda from the interface, asynchronous to i_sys_clk; registers live outside
`timescale 1ns/1ns
module irtp_target
  import irtp_pkg::*;
#(
  parameter int PWRUP_CYC = IRTP_PWRUP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  irtp_if.target bus,
  input wire logic i_dead_battery,
  output logic o_ready,
  output logic o_wr_valid,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RXB = 3'b010,
    ST_RXACK = 3'b011,
    ST_TXB = 3'b100,
    ST_TXACK = 3'b101,
    ST_WAIT = 3'b110
  } irtp_st_type;

  // ----------------------------------------
  // input synchronisers and edge finding
  // ----------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, db_sync_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      db_sync_reg <= 2'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      db_sync_reg <= {db_sync_reg[0], i_dead_battery};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  assign scl_rise = scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall = !scl_sync_reg[1] && scl_d_reg;
  assign start_cond = scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
  assign stop_cond = scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1];

  // ----------------------------------------
  // power-up delay
  // ----------------------------------------
  logic [$clog2(PWRUP_CYC+1)-1:0] pwr_cnt_reg, pwr_cnt_next;
  logic enabled;
  assign o_ready = (pwr_cnt_reg == '0);
  assign enabled = o_ready && !db_sync_reg[1];
  always_comb begin
    pwr_cnt_next = (pwr_cnt_reg != '0) ? pwr_cnt_reg - 1'b1 : pwr_cnt_reg;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pwr_cnt_reg <= $bits(pwr_cnt_reg)'(PWRUP_CYC);
    end else begin
      pwr_cnt_reg <= pwr_cnt_next;
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  irtp_st_type st_reg, st_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
  logic [3:0] bit_reg, bit_next;
  logic first_reg, first_next, rd_reg, rd_next;
  logic sda_drv_reg, sda_drv_next, wr_v_reg, wr_v_next;
  logic [7:0] wa_reg, wa_next, wd_reg, wd_next;
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    bit_next = bit_reg;
    first_next = first_reg;
    rd_next = rd_reg;
    sda_drv_next = sda_drv_reg;
    wr_v_next = 1'b0;
    wa_next = wa_reg;
    wd_next = wd_reg;
    if (!enabled || stop_cond) begin
      st_next = ST_IDLE;
      sda_drv_next = 1'b0;
    end else if (start_cond) begin
      st_next = ST_ADDR;
      bit_next = 4'h0;
      sda_drv_next = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: ;
        ST_ADDR, ST_RXB: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_sync_reg[1]};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            if (st_reg == ST_ADDR) begin
              if (sh_reg[7:1] == IRTP_TARGET_ADDR) begin
                sda_drv_next = 1'b1;
                rd_next = sh_reg[0];
                first_next = 1'b1;
                st_next = ST_RXACK;
              end else begin
                st_next = ST_IDLE;
              end
            end else begin
              sda_drv_next = 1'b1;
              st_next = ST_RXACK;
              if (first_reg) begin
                ptr_next = sh_reg;
                first_next = 1'b0;
              end else begin
                wr_v_next = 1'b1;
                wa_next = ptr_reg;
                wd_next = sh_reg;
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        ST_RXACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (rd_reg) begin
              sh_next = i_rd_data;
              sda_drv_next = !i_rd_data[7];
              st_next = ST_TXB;
            end else begin
              sda_drv_next = 1'b0;
              st_next = ST_RXB;
            end
          end
        end
        ST_TXB: begin
          if (scl_rise) begin
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_reg == 4'h8) begin
              sda_drv_next = 1'b0;
              ptr_next = ptr_reg + 8'h01;
              st_next = ST_TXACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              sda_drv_next = !sh_reg[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            st_next = sda_sync_reg[1] ? ST_WAIT : ST_RXACK;
          end
        end
        ST_WAIT: ;
        default: st_next = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      ptr_reg <= IRTP_PTR_RESET;
      bit_reg <= 4'h0;
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      wr_v_reg <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      bit_reg <= bit_next;
      first_reg <= first_next;
      rd_reg <= rd_next;
      sda_drv_reg <= sda_drv_next;
      wr_v_reg <= wr_v_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
    end
  end
  assign bus.sda_t_o = 1'b0;
  assign bus.sda_t_oe_n = !sda_drv_reg;
  assign o_wr_valid = wr_v_reg;
  assign o_wr_addr = wa_reg;
  assign o_wr_data = wd_reg;
  assign o_rd_addr = ptr_reg;
  assign o_busy = (st_reg != ST_IDLE);
endmodule

// [shared/irtp_pkg.sv]
// package for the register target port: bus address, pointer reset, timing counts
// assumes a 20 MHz system clock on both ends
package irtp_pkg;
  localparam logic [6:0] IRTP_TARGET_ADDR = 7'h20;
  localparam logic [7:0] IRTP_PTR_RESET = 8'h00;
  localparam int IRTP_CLK_HZ = 20000000;
  // power-up delay before the port answers, in microseconds
  localparam int IRTP_PWRUP_US = 10;
  localparam int IRTP_PWRUP_CYC = (IRTP_PWRUP_US * (IRTP_CLK_HZ / 1000000) > 0) ?
    IRTP_PWRUP_US * (IRTP_CLK_HZ / 1000000) : 1;
  // master bus clock: half period in system cycles (400 ns period)
  localparam int IRTP_HALF_NS = 200;
  localparam int IRTP_HALF_CYC = (IRTP_HALF_NS * (IRTP_CLK_HZ / 1000000) / 1000 > 0) ?
    IRTP_HALF_NS * (IRTP_CLK_HZ / 1000000) / 1000 : 1;
  localparam int IRTP_FIFO_DEPTH = 8;
endpackage

// [shared/irtp_if.sv]
// serial link between the port manager (master) and the register target port
// open-drain: each party drives low with its enable low; wire is pulled high
`timescale 1ns/1ns
interface irtp_if;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_t_o;
  logic sda_t_oe_n;
  logic scl;
  logic sda;
  assign scl = (!scl_m_oe_n && !scl_m_o) ? 1'b0 : 1'b1;
  assign sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_t_oe_n && !sda_t_o)) ? 1'b0 : 1'b1;
  modport master (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n,
    input scl, input sda);
  modport target (output sda_t_o, output sda_t_oe_n, input scl, input sda);
endinterface

// [design/irtp_fifo.sv]
// synchronous FIFO with valid/ready on both sides
// assumes one clock and synchronous reset
`timescale 1ns/1ns
module irtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_comb begin
    wr_next = push ? ((wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
endmodule

// [design/irtp_master.sv]
// master end: port manager side, runs combined write, pointer-only write and reads
// assumes scl/sda from the interface; makes the bus clock by dividing i_sys_clk
`timescale 1ns/1ns
module irtp_master
  import irtp_pkg::*;
#(
  parameter int HALF_CYC = IRTP_HALF_CYC,
  parameter int DEPTH = IRTP_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  irtp_if.master bus,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic i_cmd_set_ptr,
  input wire logic [7:0] i_cmd_ptr,
  input wire logic [3:0] i_cmd_len,
  input wire logic i_wdata_valid,
  output logic o_wdata_ready,
  input wire logic [7:0] i_wdata,
  output logic o_rdata_valid,
  input wire logic i_rdata_ready,
  output logic [7:0] o_rdata,
  output logic o_nack
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000, MS_START = 3'b001, MS_BYTE = 3'b010, MS_ACK = 3'b011,
    MS_STOP = 3'b100, MS_RSTART = 3'b101
  } irtp_mst_type;
  typedef enum logic [1:0] {
    PH_ADDRW = 2'b00, PH_PTR = 2'b01, PH_DATA = 2'b10, PH_ADDRR = 2'b11
  } irtp_ph_type;

  // ----------------------------------------
  // sync of sda, write data FIFO
  // ----------------------------------------
  logic [1:0] sda_sync_reg;
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) sda_sync_reg <= 2'h3;
    else sda_sync_reg <= {sda_sync_reg[0], bus.sda};
  end
  irtp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) irtp_fifo_i (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_in_valid(i_wdata_valid),
    .o_in_ready(o_wdata_ready), .i_in_data(i_wdata), .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop), .o_out_data(fifo_data));

  // ----------------------------------------
  // sequencer: quarter steps of the bus clock
  // ----------------------------------------
  irtp_mst_type st_reg, st_next;
  irtp_ph_type ph_reg, ph_next;
  logic [15:0] div_reg, div_next;
  logic [1:0] q_reg, q_next;
  logic [3:0] bit_reg, bit_next, len_reg, len_next;
  logic [7:0] sh_reg, sh_next, rd_reg, rd_next;
  logic rdv_reg, rdv_next, rdcmd_reg, rdcmd_next, nack_reg, nack_next;
  logic scl_reg, scl_next, sda_reg, sda_next, tick;
  assign tick = (div_reg == 16'(HALF_CYC / 2 - 1)) || (HALF_CYC < 2);
  assign o_cmd_ready = (st_reg == MS_IDLE);
  // head is loaded into the shifter as it is popped: once after the pointer, then per further byte
  assign fifo_pop = tick && fifo_valid && st_reg == MS_ACK && q_reg == 2'h3 && !nack_reg && !rdcmd_reg
    && ((ph_reg == PH_PTR && len_reg != 4'h0) || (ph_reg == PH_DATA && len_reg > 4'h1));
  always_comb begin
    st_next = st_reg; ph_next = ph_reg; q_next = q_reg; bit_next = bit_reg;
    len_next = len_reg; sh_next = sh_reg; rd_next = rd_reg; rdcmd_next = rdcmd_reg;
    nack_next = nack_reg; scl_next = scl_reg; sda_next = sda_reg;
    rdv_next = rdv_reg && !i_rdata_ready;
    div_next = tick ? 16'h0000 : div_reg + 16'h0001;
    if (st_reg == MS_IDLE) begin
      div_next = 16'h0000;
      if (i_cmd_valid) begin
        rdcmd_next = i_cmd_read; len_next = i_cmd_len;
        nack_next = 1'b0; q_next = 2'h0; st_next = MS_START;
        sh_next = i_cmd_ptr;
        ph_next = (i_cmd_read && !i_cmd_set_ptr) ? PH_ADDRR : PH_ADDRW;
      end
    end else if (tick && !(rdv_reg && ph_reg == PH_DATA)) begin
      q_next = q_reg + 2'h1;
      unique case (st_reg)
        MS_START, MS_RSTART: begin
          // data released while clock low, so a repeated start never looks like a stop
          if (q_reg == 2'h0) sda_next = 1'b1;
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h2) sda_next = 1'b0;
          if (q_reg == 2'h3) begin
            scl_next = 1'b0; bit_next = 4'h0; st_next = MS_BYTE;
            rd_next = {IRTP_TARGET_ADDR, ph_reg == PH_ADDRR};
          end
        end
        MS_BYTE: begin
          if (q_reg == 2'h0) sda_next = (ph_reg == PH_DATA && rdcmd_reg) ? 1'b1 : rd_reg[7];
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h2) sh_next = (ph_reg == PH_DATA && rdcmd_reg) ? {sh_reg[6:0], sda_sync_reg[1]} : sh_reg;
          if (q_reg == 2'h3) begin
            scl_next = 1'b0; rd_next = {rd_reg[6:0], 1'b0}; bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) st_next = MS_ACK;
          end
        end
        MS_ACK: begin
          if (q_reg == 2'h0) sda_next = !(ph_reg == PH_DATA && rdcmd_reg && len_reg != 4'h1);
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h2 && !(ph_reg == PH_DATA && rdcmd_reg)) nack_next = sda_sync_reg[1];
          if (q_reg == 2'h3) begin
            scl_next = 1'b0; bit_next = 4'h0; st_next = MS_BYTE;
            if (nack_reg) st_next = MS_STOP;
            else unique case (ph_reg)
              PH_ADDRW: begin ph_next = PH_PTR; rd_next = sh_reg; end
              PH_PTR: begin
                if (rdcmd_reg) begin ph_next = PH_ADDRR; st_next = MS_RSTART; end
                else if (len_reg == 4'h0) st_next = MS_STOP;
                else begin ph_next = PH_DATA; rd_next = fifo_data; end
              end
              PH_ADDRR: ph_next = PH_DATA;
              PH_DATA: begin
                if (rdcmd_reg) begin rdv_next = 1'b1; rd_next = sh_reg; end
                else rd_next = fifo_data;
                len_next = len_reg - 4'h1;
                if (len_reg <= 4'h1) st_next = MS_STOP;
              end
            endcase
          end
        end
        MS_STOP: begin
          if (q_reg == 2'h0) sda_next = 1'b0;
          if (q_reg == 2'h1) scl_next = 1'b1;
          if (q_reg == 2'h3) begin sda_next = 1'b1; st_next = MS_IDLE; end
        end
        default: st_next = MS_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_reg <= MS_IDLE; ph_reg <= PH_ADDRW; div_reg <= 16'h0000; q_reg <= 2'h0;
      bit_reg <= 4'h0; len_reg <= 4'h0; sh_reg <= 8'h00; rd_reg <= 8'h00;
      rdv_reg <= 1'b0; rdcmd_reg <= 1'b0; nack_reg <= 1'b0;
      scl_reg <= 1'b1; sda_reg <= 1'b1;
    end else begin
      st_reg <= st_next; ph_reg <= ph_next; div_reg <= div_next; q_reg <= q_next;
      bit_reg <= bit_next; len_reg <= len_next; sh_reg <= sh_next; rd_reg <= rd_next;
      rdv_reg <= rdv_next; rdcmd_reg <= rdcmd_next; nack_reg <= nack_next;
      scl_reg <= scl_next; sda_reg <= sda_next;
    end
  end
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe_n = scl_reg;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = sda_reg;
  assign o_rdata_valid = rdv_reg;
  assign o_rdata = rd_reg;
  assign o_nack = nack_reg;
endmodule

// [tb/irtp_link_assertions.sv]
// checker for the serial link between the master and target ends
// assumes the interface levels are sampled by the system clock of both ends
`timescale 1ns/1ns
module irtp_link_assertions
  import irtp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_sda_t_oe_n,
  input wire logic i_scl,
  input wire logic i_sda
);
  logic sda_t_oe_n, scl, sda;
  assign sda_t_oe_n = i_sda_t_oe_n;
  assign scl = i_scl;
  assign sda = i_sda;
  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic first_reg, first_next, rd_reg, rd_next, nack_reg, nack_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic scl_rise, start_seen, stop_seen;
  assign scl_rise = scl && !scl_q_reg;
  assign start_seen = scl && scl_q_reg && sda_q_reg && !sda;
  assign stop_seen = scl && scl_q_reg && !sda_q_reg && sda;
  always_comb begin
    scl_q_next = scl;
    sda_q_next = sda;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    first_next = first_reg;
    rd_next = rd_reg;
    nack_next = nack_reg;
    if (start_seen || stop_seen) begin
      cnt_next = 4'h0;
      first_next = 1'b1;
      rd_next = 1'b0;
      nack_next = 1'b0;
    end else if (scl_rise && cnt_reg == 4'h8) begin
      cnt_next = 4'h0;
      first_next = 1'b0;
      if (first_reg && sh_reg[0] && !sda) rd_next = 1'b1;
      if (rd_reg && sda) nack_next = 1'b1;
    end else if (scl_rise) begin
      cnt_next = cnt_reg + 4'h1;
      sh_next = {sh_reg[6:0], sda};
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      first_reg <= 1'b1;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      first_reg <= first_next;
      rd_reg <= rd_next;
      nack_reg <= nack_next;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_ack_bit;
    scl_rise && cnt_reg == 4'h8;
  endsequence
  sequence s_data_bit;
    scl_rise && cnt_reg != 4'h8;
  endsequence
  chk_addr_match: assert property (s_ack_bit ##0 (first_reg && !sda_t_oe_n) |-> sh_reg[7:1] == IRTP_TARGET_ADDR)
    else $error("target acked a foreign address");
  chk_write_listen: assert property (s_data_bit ##0 !rd_reg |-> sda_t_oe_n)
    else $error("target drove a written bit");
  chk_read_ack_free: assert property (s_ack_bit ##0 rd_reg |-> sda_t_oe_n)
    else $error("target held the master ack slot");
  chk_nack_quiet: assert property (nack_reg |-> sda_t_oe_n)
    else $error("target drove after a nack");
  chk_sda_setup: assert property ($changed(sda_t_oe_n) |-> !scl)
    else $error("target data changed with clock high");
  chk_stop_quiet: assert property (stop_seen |-> sda_t_oe_n [*8])
    else $error("target drove after stop");
  chk_start_free: assert property (start_seen |-> sda_t_oe_n)
    else $error("target drove at start");
  chk_ack_hold: assert property (s_ack_bit ##0 !sda_t_oe_n |=> !sda_t_oe_n [*2])
    else $error("target ack not held");
  cover property (s_ack_bit ##0 (rd_reg && sda));
endmodule

// [tb/i2c_register_target_port_tb.sv]
// bench joining the master and target ends through one link
// assumes the outside register space is modelled here as a byte array
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module i2c_register_target_port_tb;
  import irtp_pkg::*;
  logic clk = 1'b0, srst = 1'b1, dead_bat = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_set_ptr = 1'b0, wd_valid = 1'b0, rd_ready = 1'b0;
  logic [7:0] cmd_ptr = 8'h00, wd_data = 8'h00;
  logic [3:0] cmd_len = 4'h0;
  logic [7:0] rd_addr, wr_addr, wr_data, rdata;
  logic cmd_ready, wd_ready, rdata_valid, nack, tgt_ready, wr_valid, busy;
  logic [7:0] regs [256];
  logic [7:0] exp_regs [256];
  int err_count = 0, checks = 0, wr_seen = 0, wr_exp = 0, n;
  irtp_if bus_if ();
  irtp_master irtp_master_i (.i_sys_clk(clk), .i_srst(srst), .bus(bus_if), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read), .i_cmd_set_ptr(cmd_set_ptr), .i_cmd_ptr(cmd_ptr),
    .i_cmd_len(cmd_len), .i_wdata_valid(wd_valid), .o_wdata_ready(wd_ready), .i_wdata(wd_data),
    .o_rdata_valid(rdata_valid), .i_rdata_ready(rd_ready), .o_rdata(rdata), .o_nack(nack));
  irtp_target irtp_target_i (.i_sys_clk(clk), .i_srst(srst), .bus(bus_if), .i_dead_battery(dead_bat),
    .o_ready(tgt_ready), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_rd_addr(rd_addr), .i_rd_data(regs[rd_addr]), .o_busy(busy));
  irtp_link_assertions irtp_link_assertions_i (.i_sys_clk(clk), .i_srst(srst),
    .i_sda_t_oe_n(bus_if.sda_t_oe_n), .i_scl(bus_if.scl), .i_sda(bus_if.sda));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      regs[wr_addr] <= wr_data;
      wr_seen <= wr_seen + 1;
    end
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask
  task automatic issue(input logic rd, input logic sp, input logic [7:0] ptr, input int len);
    cmd_read = rd;
    cmd_set_ptr = sp;
    cmd_ptr = ptr;
    cmd_len = 4'(len);
    cmd_valid = 1'b1;
    for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) tick();
    if (n == 4000) timeout();
    tick();
    cmd_valid = 1'b0;
  endtask
  task automatic wait_idle(input logic exp_nack);
    for (n = 0; n < 4000 && !(cmd_ready === 1'b1 && busy === 1'b0); n++) tick();
    if (n == 4000) timeout();
    `CHK(nack, exp_nack)
  endtask
  task automatic fill(input logic [7:0] ptr, input int len);
    for (int i = 0; i < len; i++) begin
      wd_data = 8'(ptr + i) ^ 8'h5A;
      exp_regs[8'(ptr + i)] = wd_data;
      wd_valid = 1'b1;
      for (n = 0; n < 400 && wd_ready !== 1'b1; n++) tick();
      if (n == 400) timeout();
      tick();
    end
    wd_valid = 1'b0;
    wr_exp += len;
  endtask
  task automatic write(input logic [7:0] ptr, input int len);
    fill(ptr, len);
    issue(1'b0, 1'b1, ptr, len);
    wait_idle(1'b0);
  endtask
  task automatic read_chk(input logic sp, input logic [7:0] ptr, input int len, input int stall);
    issue(1'b1, sp, ptr, len);
    repeat (stall) tick();
    rd_ready = 1'b1;
    for (int i = 0; i < len; i++) begin
      for (n = 0; n < 4000 && rdata_valid !== 1'b1; n++) tick();
      if (n == 4000) timeout();
      `CHK(rdata, exp_regs[8'(ptr + i)])
      tick();
    end
    rd_ready = 1'b0;
    wait_idle(1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'hA5;
      exp_regs[i] = 8'(i) ^ 8'hA5;
    end
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    issue(1'b1, 1'b0, 8'h00, 1);
    wait_idle(1'b1);
    `CHK(tgt_ready, 1'b0)
    for (n = 0; n < 400 && tgt_ready !== 1'b1; n++) tick();
    if (n == 400) timeout();
    `CHK(tgt_ready, 1'b1)
    dead_bat = 1'b1;
    issue(1'b0, 1'b1, 8'h40, 0);
    wait_idle(1'b1);
    dead_bat = 1'b0;
    read_chk(1'b0, 8'h00, 3, 0);
    write(8'hFE, 3);
    read_chk(1'b1, 8'hFE, 3, 20);
    read_chk(1'b0, 8'h01, 2, 0);
    issue(1'b0, 1'b1, 8'h40, 0);
    wait_idle(1'b0);
    read_chk(1'b0, 8'h40, 1, 0);
    fill(8'h80, 8);
    `CHK(wd_ready, 1'b0)
    issue(1'b0, 1'b1, 8'h80, 8);
    wait_idle(1'b0);
    read_chk(1'b1, 8'h80, 8, 40);
    `CHK(wr_seen, wr_exp)
    // mid-run reset: pointer back to zero once the port answers again
    srst = 1'b1;
    repeat (16) tick();
    srst = 1'b0;
    for (n = 0; n < 400 && tgt_ready !== 1'b1; n++) tick();
    if (n == 400) timeout();
    read_chk(1'b0, 8'h00, 1, 0);
    test_done();
  end
endmodule
